//--- include/sdp_pkg.sv
// constants of the stepper driver spi datagram port
package sdp_pkg;
   // datagram layout
   localparam int FRAME_BITS = 40;
   localparam int DATA_BITS = 32;
   localparam int ADDR_BITS = 7;
   localparam int STAT_BITS = 8;
   localparam int WR_BIT = 39;
   localparam int ADDR_MSB = 38;
   localparam int ADDR_LSB = 32;
   // register addresses
   localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
   localparam logic [6:0] ADDR_ACTUAL_POSITION = 7'h21;
   localparam logic [6:0] ADDR_ACTUAL_VELOCITY = 7'h22;
   localparam logic [6:0] ADDR_VELOCITY_LIMIT = 7'h27;
   localparam logic [6:0] ADDR_DRIVER_STATUS = 7'h6F;
   // field positions
   localparam int GS_RESET = 0;
   localparam int GS_DRV_ERR = 1;
   localparam int DS_STANDSTILL = 31;
   localparam int DS_STALL = 24;
   localparam int ST_RESET = 0;
   localparam int ST_DRV_ERR = 1;
   localparam int ST_STALL = 2;
   localparam int ST_STANDSTILL = 3;
   // reset values
   localparam logic [1:0] RST_GLOBAL_STATUS = 2'h1;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [39:0] RST_FRAME = 40'h00_0000_0000;
   // bit counting
   localparam logic [5:0] CNT_ZERO = 6'h00;
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam logic [5:0] CNT_MAX = 6'h3F;
   localparam logic [5:0] MIN_BITS = 6'h28;
endpackage

//--- rtl/sdp_sync.sv
// two-stage synchroniser for the spi pins
`timescale 1ns/10ps
module sdp_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] INIT = '0
) (
   // clocking
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sys_rst,
   // pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else if (clk_en) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule // sdp_sync

//--- rtl/sdp_spi_port.sv
// spi datagram port with register set of the stepper driver
`timescale 1ns/10ps
// Notes on behaviour
// - each transfer is a 40-bit datagram: address byte then four data bytes.
// - every access carries a full 32-bit word, unused bits included.
// - datagram bit 39 set means write, clear means read; seven address bits follow.
// - a full reply datagram goes out on every access.
// - after a read, reply data is the register addressed by that read.
// - after a write, reply data echoes the write data just received.
// - a read leaves the register untouched; its data bits are dummies.
// - reads pipeline back to back; one extra datagram completes the last read.
// - every reply carries eight status bits in datagram bits 39 to 32.
// - status snapshot taken at end of access, sent in the next transfer.
// - all registers readable; most read/write, some read-only, global flags write-one-clear.
// - sample input on rising clock, update output after falling edge, msb first.
// - at chip select rise the last 40 received bits form the command.
// - bits beyond the 40th reappear on the output 40 clocks later.
// - status bits: 3 standstill, 2 stall, 1 driver error, 0 reset; 7:4 zero.
module sdp_spi_port (
   // clocking
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sys_rst,
   // spi pins
   input wire logic sck,
   input wire logic sdi,
   input wire logic chip_select_n,
   output logic sdo,
   output logic sdo_oe,
   // motor core status
   input wire logic standstill,
   input wire logic stall_flag,
   input wire logic driver_error,
   // register contents to the motor core
   output logic [31:0] actual_position,
   output logic [31:0] actual_velocity,
   output logic [31:0] velocity_limit
);
   localparam int WR_BIT = sdp_pkg::WR_BIT;
   localparam int FRAME_BITS = sdp_pkg::FRAME_BITS;
   localparam int DATA_BITS = sdp_pkg::DATA_BITS;
   localparam int ADDR_MSB = sdp_pkg::ADDR_MSB;
   localparam int ADDR_LSB = sdp_pkg::ADDR_LSB;

   // pin synchronisation
   wire [2:0] pins_s;
   wire cs_n_s;
   wire sck_s;
   wire sdi_s;

   // pins are asynchronous to clk, so all go through two flops
   sdp_sync #(
      .W(3),
      .INIT(3'h6)
   ) u_sync (
      .clk(clk),
      .clk_en(clk_en),
      .sys_rst(sys_rst),
      .d({chip_select_n, sck, sdi}),
      .q(pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign sdi_s = pins_s[0];

   // state
   logic sck_q;
   logic cs_n_q;
   logic frame_q;
   logic first_q;
   logic in_bit_q;
   logic [5:0] cnt_q;
   logic [39:0] shreg_q;
   logic [39:0] shreg_d;
   logic [31:0] reply_q;
   logic [31:0] reply_d;
   logic [7:0] status_q;
   logic [1:0] global_status_flags_q;
   logic [1:0] global_status_flags_d;
   logic [31:0] pos_q;
   logic [31:0] vel_q;
   logic [31:0] vlim_q;

   // edge detection on synchronised pins
   wire cs_fall = cs_n_q & ~cs_n_s;
   wire cs_rise = ~cs_n_q & cs_n_s & frame_q;
   wire sck_rise = ~sck_q & sck_s & frame_q;
   wire sck_fall = sck_q & ~sck_s & frame_q;
   // mode 3 idles high: the first falling edge must not shift out bit 39
   wire shift_en = sck_fall & ~first_q;

   // command decode
   wire [39:0] cmd = {shreg_q[FRAME_BITS-2:0], in_bit_q};
   wire cmd_wr = cmd[WR_BIT];
   wire [6:0] cmd_addr = cmd[ADDR_MSB:ADDR_LSB];
   wire [31:0] cmd_data = cmd[DATA_BITS-1:0];
   // short frames are dropped rather than half-executed
   wire exec = cs_rise & (cnt_q >= sdp_pkg::MIN_BITS);
   wire wr_en = exec & cmd_wr;
   wire wr_gs = wr_en & (cmd_addr == sdp_pkg::ADDR_GLOBAL_STATUS);
   wire wr_pos = wr_en & (cmd_addr == sdp_pkg::ADDR_ACTUAL_POSITION);
   wire wr_vel = wr_en & (cmd_addr == sdp_pkg::ADDR_ACTUAL_VELOCITY);
   wire wr_vlim = wr_en & (cmd_addr == sdp_pkg::ADDR_VELOCITY_LIMIT);

   // read selection, unmapped addresses read zero
   wire [31:0] drv_status = ({31'h0000_0000, standstill} << sdp_pkg::DS_STANDSTILL)
                          | ({31'h0000_0000, stall_flag} << sdp_pkg::DS_STALL);
   wire [31:0] rd_data =
      (cmd_addr == sdp_pkg::ADDR_GLOBAL_STATUS) ? {30'h0000_0000, global_status_flags_q} :
      (cmd_addr == sdp_pkg::ADDR_ACTUAL_POSITION) ? pos_q :
      (cmd_addr == sdp_pkg::ADDR_ACTUAL_VELOCITY) ? vel_q :
      (cmd_addr == sdp_pkg::ADDR_VELOCITY_LIMIT) ? vlim_q :
      (cmd_addr == sdp_pkg::ADDR_DRIVER_STATUS) ? drv_status : 32'h0000_0000;

   // live status byte, upper nibble tied low
   wire [7:0] live_status = {4'h0, standstill, stall_flag,
                             global_status_flags_q[sdp_pkg::GS_DRV_ERR], global_status_flags_q[sdp_pkg::GS_RESET]};

   // next values
   assign shreg_d = cs_fall ? {status_q, reply_q} :
                    shift_en ? {shreg_q[FRAME_BITS-2:0], in_bit_q} : shreg_q;
   assign reply_d = exec ? (cmd_wr ? cmd_data : rd_data) : reply_q;
   // a new error in the clearing cycle survives the clear
   assign global_status_flags_d = (global_status_flags_q & ~(wr_gs ? cmd_data[1:0] : 2'h0))
                  | {driver_error, 1'b0};

   // pin edge history and framing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_q <= 1'b1;
         cs_n_q <= 1'b1;
         frame_q <= 1'b0;
         first_q <= 1'b0;
      end else if (clk_en) begin
         sck_q <= sck_s;
         cs_n_q <= cs_n_s;
         frame_q <= cs_fall | (frame_q & ~cs_rise);
         first_q <= cs_fall | (first_q & ~sck_fall);
      end
   end

   // serial shifting and bit count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_bit_q <= 1'b0;
         cnt_q <= sdp_pkg::CNT_ZERO;
         shreg_q <= sdp_pkg::RST_FRAME;
      end else if (clk_en) begin
         if (sck_rise) begin
            in_bit_q <= sdi_s;
         end
         if (cs_fall) begin
            cnt_q <= sdp_pkg::CNT_ZERO;
         end else if (sck_rise && cnt_q != sdp_pkg::CNT_MAX) begin
            cnt_q <= cnt_q + sdp_pkg::CNT_ONE;
         end
         shreg_q <= shreg_d;
      end
   end

   // reply and status snapshot
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reply_q <= sdp_pkg::RST_WORD;
         status_q <= sdp_pkg::RST_STATUS;
      end else if (clk_en) begin
         reply_q <= reply_d;
         if (exec) begin
            status_q <= live_status;
         end
      end
   end

   // register set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         global_status_flags_q <= sdp_pkg::RST_GLOBAL_STATUS;
         pos_q <= sdp_pkg::RST_WORD;
         vel_q <= sdp_pkg::RST_WORD;
         vlim_q <= sdp_pkg::RST_WORD;
      end else if (clk_en) begin
         global_status_flags_q <= global_status_flags_d;
         if (wr_pos) begin
            pos_q <= cmd_data;
         end
         if (wr_vel) begin
            vel_q <= cmd_data;
         end
         if (wr_vlim) begin
            vlim_q <= cmd_data;
         end
      end
   end

   // outputs; sdo holds while deselected, sampled only inside a frame
   assign sdo = shreg_q[WR_BIT];
   assign sdo_oe = frame_q;
   assign actual_position = pos_q;
   assign actual_velocity = vel_q;
   assign velocity_limit = vlim_q;

   // helper: a datagram has completed since reset
   logic done_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (clk_en && exec) begin
         done_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_write_stores: assert property (
      (clk_en && wr_vlim) |=> (vlim_q == $past(cmd_data)))
      else $error("write did not reach velocity limit");

   a_read_no_change: assert property (
      (clk_en && exec && !cmd_wr) |=> ($stable(pos_q) && $stable(vel_q) && $stable(vlim_q)))
      else $error("read modified a register");

   a_write_echo: assert property (
      (clk_en && exec && cmd_wr) |=> (reply_q == $past(cmd_data)))
      else $error("write data not echoed");

   a_read_pipe: assert property (
      (clk_en && exec && !cmd_wr) |=> (reply_q == $past(rd_data)))
      else $error("read data not returned next");

   a_status_snap: assert property (
      (clk_en && exec) |=> (status_q == $past(live_status)))
      else $error("status snapshot missing");

   a_reply_load: assert property (
      (clk_en && cs_fall) |=> (shreg_q == {$past(status_q), $past(reply_q)}) && sdo_oe)
      else $error("reply not loaded at frame start");

   a_shift_step: assert property (
      (clk_en && shift_en) |=> (shreg_q == {$past(shreg_q[38:0]), $past(in_bit_q)}))
      else $error("shift register did not advance");

   a_first_hold: assert property (
      (clk_en && first_q && !cs_fall) |=> $stable(shreg_q))
      else $error("first falling edge shifted the reply");

   a_reset_reply: assert property (
      !done_q |-> (reply_q == 32'h0000_0000 && status_q == 8'h00))
      else $error("stale reply after reset");

   a_status_unused: assert property (
      status_q[7:4] == 4'h0)
      else $error("unused status bits set");

   a_w1c_clear: assert property (
      (clk_en && wr_gs && !driver_error) |=> ((global_status_flags_q & $past(cmd_data[1:0])) == 2'h0))
      else $error("global flag not cleared");

   a_err_wins: assert property (
      (clk_en && driver_error) |=> global_status_flags_q[1])
      else $error("driver error lost");

   c_read: cover property (clk_en && exec && !cmd_wr);
   c_write_pos: cover property (clk_en && wr_pos);
   c_daisy: cover property (clk_en && exec && cnt_q > sdp_pkg::MIN_BITS);
   c_gs_clear: cover property (clk_en && wr_gs && cmd_data[0]);
endmodule // sdp_spi_port

//--- test/sdp_ctrl_model.sv
// spi bus controller model, mode 3, for the datagram port
`timescale 1ns/10ps
module sdp_ctrl_model (
   // spi pins
   output logic sck,
   output logic sdi,
   output logic chip_select_n,
   input wire logic sdo
);
   initial begin
      sck = 1'b1;
      sdi = 1'b0;
      chip_select_n = 1'b1;
   end
   // n bits msb first; clock stands high between frames
   task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
      rx = '0;
      // move chip select 1.25 ns off the call time; the later 24 ns steps can still land on system clock edges
      #1.25;
      chip_select_n = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         sck = 1'b0;
         sdi = tx[i];
         #24;
         sck = 1'b1;
         rx = {rx[62:0], sdo};
         #24;
      end
      chip_select_n = 1'b1;
      // released line must not keep showing the last bit
      sdi = ~sdi;
      #100;
   endtask
endmodule // sdp_ctrl_model

//--- test/sdp_spi_port_bench.sv
// testbench of the spi datagram port
`timescale 1ns/10ps
module sdp_spi_port_bench;
   logic clk, clk_en, sys_rst, sck, sdi, chip_select_n, sdo, sdo_oe;
   logic standstill, stall_flag, driver_error;
   logic [31:0] actual_position, actual_velocity, velocity_limit;
   logic [63:0] rx;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   sdp_spi_port dut (
      .clk(clk), .clk_en(clk_en), .sys_rst(sys_rst),
      .sck(sck), .sdi(sdi), .chip_select_n(chip_select_n), .sdo(sdo), .sdo_oe(sdo_oe),
      .standstill(standstill), .stall_flag(stall_flag), .driver_error(driver_error),
      .actual_position(actual_position), .actual_velocity(actual_velocity),
      .velocity_limit(velocity_limit)
   );
   sdp_ctrl_model ctrl (.sck(sck), .sdi(sdi), .chip_select_n(chip_select_n), .sdo(sdo));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // full 40-bit frame, reply compared whole
   task automatic frame(input logic [39:0] tx, input logic [39:0] exp);
      ctrl.xfer(40, {24'h0, tx}, rx);
      check(rx, {24'h0, exp});
   endtask
   // whole run is some 14 frames of about 400 cycles each
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      clk_en = 1'b1;
      sys_rst = 1'b1;
      standstill = 1'b1;
      stall_flag = 1'b0;
      driver_error = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      frame(40'hA1_1234_5678, 40'h00_0000_0000);
      check({32'h0, actual_position}, 64'h1234_5678);
      @(posedge clk);
      stall_flag <= 1'b1;
      frame(40'h21_FFFF_FFFF, 40'h09_1234_5678);
      check({32'h0, actual_position}, 64'h1234_5678);
      frame(40'h81_0000_0001, 40'h0D_1234_5678);
      ctrl.xfer(40, 64'h01_0000_0000, rx);
      // snapshot was taken before the clear landed
      check(rx, 64'h0D_0000_0001);
      @(posedge clk);
      driver_error <= 1'b1;
      @(posedge clk);
      driver_error <= 1'b0;
      frame(40'h21_0000_0000, 40'h0C_0000_0000);
      ctrl.xfer(39, 64'h50_DEAD_BEEF, rx);
      check(rx, 64'h07_091A_2B3C);
      check({32'h0, actual_position}, 64'h1234_5678);
      ctrl.xfer(48, 64'h5A_A2CA_FEF0_0D, rx);
      check(rx, 64'h0E_1234_5678_5A);
      check({32'h0, actual_velocity}, 64'hCAFE_F00D);
      frame(40'hA7_00AB_CDEF, 40'h0E_CAFE_F00D);
      check({32'h0, velocity_limit}, 64'h00AB_CDEF);
      frame(40'h6F_0000_0000, 40'h0E_00AB_CDEF);
      frame(40'h7F_0000_0000, 40'h0E_8100_0000);
      frame(40'hEF_FFFF_FFFF, 40'h0E_0000_0000);
      frame(40'h01_0000_0000, 40'h0E_FFFF_FFFF);
      frame(40'h6F_0000_0000, 40'h0E_0000_0002);
      frame(40'h00_0000_0000, 40'h0E_8100_0000);
      check({63'h0, sdo_oe}, 64'h0);
      end_sim();
   end
endmodule // sdp_spi_port_bench
